// ===== core/pud_defaults_store.sv
// command handler that stores and reads back the power-up defaults
module pud_defaults_store
  import pud_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_last,
  output logic            o_rx_ready,
  output logic            o_tx_valid,
  output logic      [7:0] o_tx_data,
  output logic            o_tx_last,
  input  wire logic       i_tx_ready,
  output logic            o_flash_req,
  output logic            o_flash_we,
  output logic      [7:0] o_flash_addr,
  output logic      [7:0] o_flash_wdata,
  input  wire logic       i_flash_ack,
  input  wire logic [7:0] i_flash_rdata,
  output logic      [7:0] o_live_addr,
  input  wire logic [7:0] i_live_data,
  output logic            o_busy
);
  import pud_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pud_state_t        state, next_state;
  pud_op_t           op, next_op;
  logic [7:0][7:0]   cmd, next_cmd;
  logic [7:0]        idx, next_idx;
  logic [2:0]        map_block_select, next_map_block_select;
  logic              frame_err, next_frame_err;
  logic              resp_long, next_resp_long;
  logic [7:0]        err, next_err;
  logic [15:0]       dsum, next_dsum;
  logic [5:0]        tx_idx, next_tx_idx;
  logic              next_rx_ready, next_tx_valid, next_tx_last;
  logic [7:0]        next_tx_data;
  logic              next_flash_req, next_flash_we;
  logic [7:0]        next_flash_addr, next_flash_wdata, next_live_addr;
  logic              next_busy;
  logic [7:0]        resp_buf [32];
  logic              buf_we;
  logic [7:0]        buf_wdata;
  logic [7:0]        rom_data;
  logic [7:0]        header_sum_byte;
  logic [15:0]       payload_sum_word;
  logic [7:0]        hdr8;
  logic [15:0]       resp16;
  logic [5:0]        nb;
  logic [5:0]        last_idx;
  logic [7:0]        map_addr;
  logic [7:0]        src_data;
  logic              got;

  pud_factory_rom u_rom
  (
    .i_addr (o_live_addr),
    .o_data (rom_data)
  );

  // ----------------------------------------------------------------
  // frame sums
  // ----------------------------------------------------------------
  always_comb
  begin
    header_sum_byte  = 8'(cmd[POS_SYNC] + cmd[POS_WORDS] + cmd[POS_CODE]
                         + cmd[POS_SUM16_LO] + cmd[POS_SUM16_HI]);
    payload_sum_word = 16'({8'h00, cmd[POS_KEY0]} + {8'h00, cmd[POS_KEY1]});
    resp16   = 16'({8'h00, err} + (resp_long ? dsum : 16'h0000));
    hdr8     = 8'(SYNC_BYTE + CMD_WORDS + CMD_CODE + resp16[7:0] + resp16[15:8]);
    last_idx = resp_long ? RESP_LONG_LAST : RESP_SHORT_LAST;
    map_addr = resp_long ? {map_block_select, idx[4:0]} : idx;
    nb       = (state == ST_RESP) ? 6'h00 : 6'(tx_idx + 6'h01);
    case (op)
      OP_READ_FLASH: src_data = i_flash_rdata;
      OP_STORE_FACT: src_data = rom_data;
      default:       src_data = i_live_data;
    endcase
  end

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state            = state;
    next_op               = op;
    next_cmd              = cmd;
    next_idx              = idx;
    next_map_block_select = map_block_select;
    next_frame_err        = frame_err;
    next_resp_long        = resp_long;
    next_err              = err;
    next_dsum             = dsum;
    next_tx_idx           = tx_idx;
    next_rx_ready         = o_rx_ready;
    next_tx_valid         = o_tx_valid;
    next_tx_data          = o_tx_data;
    next_tx_last          = o_tx_last;
    next_flash_req        = o_flash_req;
    next_flash_we         = o_flash_we;
    next_flash_addr       = o_flash_addr;
    next_flash_wdata      = o_flash_wdata;
    next_live_addr        = o_live_addr;
    buf_we                = 1'b0;
    buf_wdata             = src_data;
    got                   = (op != OP_READ_FLASH) || i_flash_ack;
    unique case (state)
      ST_RECV:
        if (i_rx_valid && o_rx_ready)
        begin
          next_cmd[idx[2:0]] = i_rx_data;
          if (idx[2:0] == CMD_LAST || i_rx_last)
          begin
            next_frame_err = !(idx[2:0] == CMD_LAST && i_rx_last);
            next_rx_ready  = 1'b0;
            next_state     = ST_CHECK;
          end
          else
            next_idx = 8'(idx + 8'h01);
        end
      ST_CHECK:
      begin
        next_idx       = 8'h00;
        next_dsum      = 16'h0000;
        next_err       = ERR_NONE;
        next_resp_long = !frame_err && (cmd[POS_KEY0] == READ_TAG);
        next_state     = ST_RESP;
        if (frame_err)
          next_err = ERR_FRAME;
        else if (cmd[POS_SYNC] != SYNC_BYTE || cmd[POS_WORDS] != CMD_WORDS
                 || cmd[POS_CODE] != CMD_CODE)
          next_err = ERR_HEADER;
        else if (header_sum_byte != cmd[POS_SUM8]
                 || payload_sum_word != {cmd[POS_SUM16_HI], cmd[POS_SUM16_LO]})
          next_err = ERR_CHECKSUM;
        else if (cmd[POS_KEY0] == READ_TAG)
        begin
          if ({1'b0, cmd[POS_KEY1][6:0]} > BLOCK_MAX)
            next_err = ERR_BLOCK;
          else
          begin
            next_map_block_select = cmd[POS_KEY1][2:0];
            next_op = cmd[POS_KEY1][LIVE_FLAG_BIT] ? OP_READ_LIVE : OP_READ_FLASH;
            next_state = ST_ADDR;
          end
        end
        else if (cmd[POS_KEY0] == KEY_LIVE_0 && cmd[POS_KEY1] == KEY_LIVE_1)
        begin
          next_op    = OP_STORE_LIVE;
          next_state = ST_ADDR;
        end
        else if (cmd[POS_KEY0] == KEY_FACT_0 && cmd[POS_KEY1] == KEY_FACT_1)
        begin
          next_op    = OP_STORE_FACT;
          next_state = ST_ADDR;
        end
        else
          next_err = ERR_KEY;
      end
      ST_ADDR:
      begin
        next_live_addr = map_addr;
        if (op == OP_READ_FLASH)
        begin
          next_flash_req  = 1'b1;
          next_flash_we   = 1'b0;
          next_flash_addr = map_addr;
        end
        next_state = ST_WAIT;
      end
      ST_WAIT:
        if (got)
        begin
          next_flash_req = 1'b0;
          if (resp_long)
          begin
            buf_we    = 1'b1;
            next_dsum = 16'(dsum + {8'h00, src_data});
            if (idx[4:0] == BLOCK_LAST)
              next_state = ST_RESP;
            else
            begin
              next_idx   = 8'(idx + 8'h01);
              next_state = ST_ADDR;
            end
          end
          else
          begin
            next_flash_req   = 1'b1;
            next_flash_we    = 1'b1;
            next_flash_addr  = idx;
            next_flash_wdata = src_data;
            next_state       = ST_WRITE;
          end
        end
      ST_WRITE:
        if (i_flash_ack)
        begin
          next_flash_req = 1'b0;
          next_flash_we  = 1'b0;
          if (idx == MAP_LAST)
            next_state = ST_RESP;
          else
          begin
            next_idx   = 8'(idx + 8'h01);
            next_state = ST_ADDR;
          end
        end
      ST_RESP:
      begin
        next_tx_valid = 1'b1;
        next_tx_idx   = 6'h00;
        next_tx_last  = 1'b0;
        next_state    = ST_SEND;
      end
      ST_SEND:
        if (i_tx_ready)
        begin
          if (o_tx_last)
          begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            next_rx_ready = 1'b1;
            next_idx      = 8'h00;
            next_state    = ST_RECV;
          end
          else
          begin
            next_tx_idx  = nb;
            next_tx_last = (nb == last_idx);
          end
        end
    endcase
    if ((state == ST_RESP) || (state == ST_SEND && i_tx_ready && !o_tx_last))
      case (nb)
        6'h00:   next_tx_data = hdr8;
        6'h01:   next_tx_data = SYNC_BYTE;
        6'h02:   next_tx_data = CMD_WORDS;
        6'h03:   next_tx_data = CMD_CODE;
        6'h04:   next_tx_data = resp16[7:0];
        6'h05:   next_tx_data = resp16[15:8];
        6'h06:   next_tx_data = err;
        6'h07:   next_tx_data = PAD_BYTE;
        default: next_tx_data = (err == ERR_NONE) ? resp_buf[5'(nb - DATA_FIRST)] : PAD_BYTE;
      endcase
    next_busy = (next_state != ST_RECV);
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state            <= ST_RECV;
      op               <= OP_STORE_LIVE;
      cmd              <= '0;
      idx              <= 8'h00;
      map_block_select <= 3'h0;
      frame_err        <= 1'b0;
      resp_long        <= 1'b0;
      err              <= ERR_NONE;
      dsum             <= 16'h0000;
      tx_idx           <= 6'h00;
      o_rx_ready       <= 1'b1;
      o_tx_valid       <= 1'b0;
      o_tx_data        <= 8'h00;
      o_tx_last        <= 1'b0;
      o_flash_req      <= 1'b0;
      o_flash_we       <= 1'b0;
      o_flash_addr     <= 8'h00;
      o_flash_wdata    <= 8'h00;
      o_live_addr      <= 8'h00;
      o_busy           <= 1'b0;
    end
    else if (i_ce)
    begin
      state            <= next_state;
      op               <= next_op;
      cmd              <= next_cmd;
      idx              <= next_idx;
      map_block_select <= next_map_block_select;
      frame_err        <= next_frame_err;
      resp_long        <= next_resp_long;
      err              <= next_err;
      dsum             <= next_dsum;
      tx_idx           <= next_tx_idx;
      o_rx_ready       <= next_rx_ready;
      o_tx_valid       <= next_tx_valid;
      o_tx_data        <= next_tx_data;
      o_tx_last        <= next_tx_last;
      o_flash_req      <= next_flash_req;
      o_flash_we       <= next_flash_we;
      o_flash_addr     <= next_flash_addr;
      o_flash_wdata    <= next_flash_wdata;
      o_live_addr      <= next_live_addr;
      o_busy           <= next_busy;
    end
  end

  // block buffer, no reset needed
  always_ff @(posedge i_clock)
  begin
    if (i_ce && buf_we)
      resp_buf[idx[4:0]] <= buf_wdata;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LIVE_KEY: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_ce && state == ST_CHECK && !frame_err && cmd[POS_KEY0] == KEY_LIVE_0
     && cmd[POS_KEY1] == KEY_LIVE_1 && header_sum_byte == cmd[POS_SUM8]
     && cmd[POS_SYNC] == SYNC_BYTE && cmd[POS_WORDS] == CMD_WORDS
     && cmd[POS_CODE] == CMD_CODE
     && payload_sum_word == {cmd[POS_SUM16_HI], cmd[POS_SUM16_LO]})
    |=> (op == OP_STORE_LIVE && state == ST_ADDR))
    else $error("live store keys not acted on");
  AST_FACT_DATA: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_flash_req && o_flash_we && op == OP_STORE_FACT) |-> (o_flash_wdata == rom_data))
    else $error("factory store wrote a wrong byte");
  AST_RESP_HDR: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_tx_valid && tx_idx == 6'h03) |-> (o_tx_data == CMD_CODE))
    else $error("answer byte 3 wrong");
  AST_RESP_SYNC: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_tx_valid && tx_idx == 6'h01) |-> (o_tx_data == SYNC_BYTE))
    else $error("answer byte 1 wrong");
  AST_RESP_LEN: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_tx_valid && o_tx_last) |-> (tx_idx == (resp_long ? RESP_LONG_LAST : RESP_SHORT_LAST)))
    else $error("answer length wrong");
  AST_BLOCK_ADDR: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_flash_req && !o_flash_we) |-> (op == OP_READ_FLASH
     && o_flash_addr[7:5] == map_block_select))
    else $error("flash read outside selected block");
  AST_BAD_SUM: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_ce && state == ST_CHECK && header_sum_byte != cmd[POS_SUM8])
    |=> (err != ERR_NONE && state == ST_RESP))
    else $error("checksum mismatch not rejected");
  AST_HDR_SUM: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_tx_valid && tx_idx == 6'h00) |-> (o_tx_data == hdr8))
    else $error("answer byte 0 wrong");

endmodule // pud_defaults_store

// ===== core/pud_pkg.sv
// constants and types shared by the power-up defaults store
package pud_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE      = 8'hF8;
  localparam logic [7:0] CMD_WORDS      = 8'h01;
  localparam logic [7:0] CMD_CODE       = 8'h0E;
  localparam logic [7:0] READ_TAG       = 8'h00;
  localparam logic [7:0] PAD_BYTE       = 8'h00;
  localparam logic [7:0] KEY_LIVE_0     = 8'hBA;
  localparam logic [7:0] KEY_LIVE_1     = 8'h26;
  localparam logic [7:0] KEY_FACT_0     = 8'h82;
  localparam logic [7:0] KEY_FACT_1     = 8'hC7;
  localparam int         POS_SUM8       = 0;
  localparam int         POS_SYNC       = 1;
  localparam int         POS_WORDS      = 2;
  localparam int         POS_CODE       = 3;
  localparam int         POS_SUM16_LO   = 4;
  localparam int         POS_SUM16_HI   = 5;
  localparam int         POS_KEY0       = 6;
  localparam int         POS_KEY1       = 7;
  localparam int         LIVE_FLAG_BIT  = 7;
  localparam logic [7:0] BLOCK_MAX      = 8'h07;
  localparam logic [2:0] CMD_LAST       = 3'h7;
  localparam logic [5:0] RESP_SHORT_LAST = 6'h07;
  localparam logic [5:0] RESP_LONG_LAST = 6'h27;
  localparam logic [5:0] DATA_FIRST     = 6'h08;
  localparam logic [4:0] BLOCK_LAST     = 5'h1F;
  localparam logic [7:0] MAP_LAST       = 8'hFF;

  // ----------------------------------------------------------------
  // error codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_FRAME      = 8'h01;
  localparam logic [7:0] ERR_CHECKSUM   = 8'h02;
  localparam logic [7:0] ERR_HEADER     = 8'h03;
  localparam logic [7:0] ERR_KEY        = 8'h04;
  localparam logic [7:0] ERR_BLOCK      = 8'h05;

  // ----------------------------------------------------------------
  // defaults map offsets and factory values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_FLEX_DIR     = 8'h04;
  localparam logic [7:0]  RST_FLEX_DIR     = 8'h00;
  localparam logic [7:0]  OFS_FLEX_LVL     = 8'h05;
  localparam logic [7:0]  RST_FLEX_LVL     = 8'hFF;
  localparam logic [7:0]  OFS_FLEX_ANA     = 8'h06;
  localparam logic [7:0]  RST_FLEX_ANA     = 8'h00;
  localparam logic [7:0]  OFS_EXT_DIR      = 8'h08;
  localparam logic [7:0]  RST_EXT_DIR      = 8'h00;
  localparam logic [7:0]  OFS_EXT_LVL      = 8'h09;
  localparam logic [7:0]  RST_EXT_LVL      = 8'hFF;
  localparam logic [7:0]  OFS_EXT_ANA      = 8'h0A;
  localparam logic [7:0]  RST_EXT_ANA      = 8'h00;
  localparam logic [7:0]  OFS_CTL_DIR      = 8'h0C;
  localparam logic [7:0]  RST_CTL_DIR      = 8'h00;
  localparam logic [7:0]  OFS_CTL_LVL      = 8'h0D;
  localparam logic [7:0]  RST_CTL_LVL      = 8'hFF;
  localparam logic [7:0]  OFS_UPD_MASK     = 8'h10;
  localparam logic [7:0]  RST_UPD_MASK     = 8'h00;
  localparam logic [7:0]  OFS_TIMER_COUNT  = 8'h11;
  localparam logic [7:0]  RST_TIMER_COUNT  = 8'h00;
  localparam logic [7:0]  OFS_CNT_ENABLE   = 8'h12;
  localparam logic [7:0]  RST_CNT_ENABLE   = 8'h00;
  localparam logic [7:0]  OFS_PIN_START    = 8'h13;
  localparam logic [7:0]  RST_PIN_START    = 8'h04;
  localparam logic [7:0]  OFS_OPTIONS      = 8'h14;
  localparam logic [7:0]  RST_OPTIONS      = 8'h00;
  localparam logic [7:0]  OFS_TCLK_SEL     = 8'h20;
  localparam logic [7:0]  RST_TCLK_SEL     = 8'h02;
  localparam logic [7:0]  OFS_TCLK_DIV     = 8'h21;
  localparam logic [7:0]  RST_TCLK_DIV     = 8'h00;
  localparam logic [7:0]  OFS_T0_MODE      = 8'h30;
  localparam logic [7:0]  RST_T0_MODE      = 8'h0A;
  localparam logic [7:0]  OFS_T0_LOW       = 8'h31;
  localparam logic [7:0]  RST_T0_LOW       = 8'h00;
  localparam logic [7:0]  OFS_T0_HIGH      = 8'h32;
  localparam logic [7:0]  RST_T0_HIGH      = 8'h00;
  localparam logic [7:0]  OFS_T1_MODE      = 8'h34;
  localparam logic [7:0]  RST_T1_MODE      = 8'h0A;
  localparam logic [7:0]  OFS_T1_LOW       = 8'h35;
  localparam logic [7:0]  RST_T1_LOW       = 8'h00;
  localparam logic [7:0]  OFS_T1_HIGH      = 8'h36;
  localparam logic [7:0]  RST_T1_HIGH      = 8'h00;
  localparam logic [7:0]  OFS_AOUT0        = 8'h50;
  localparam logic [15:0] RST_AOUT0        = 16'h0000;
  localparam logic [7:0]  OFS_AOUT1        = 8'h54;
  localparam logic [15:0] RST_AOUT1        = 16'h0000;
  localparam logic [7:0]  OFS_NEG_CH       = 8'h60;
  localparam logic [7:0]  OFS_NEG_CH_LAST  = 8'h6F;
  localparam logic [7:0]  RST_NEG_CH       = 8'h1F;
  localparam logic [7:0]  RST_UNUSED       = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_RECV  = 7'b0000001,
    ST_CHECK = 7'b0000010,
    ST_ADDR  = 7'b0000100,
    ST_WAIT  = 7'b0001000,
    ST_WRITE = 7'b0010000,
    ST_RESP  = 7'b0100000,
    ST_SEND  = 7'b1000000
  } pud_state_t;

  typedef enum logic [1:0] {
    OP_STORE_LIVE = 2'h0,
    OP_STORE_FACT = 2'h1,
    OP_READ_FLASH = 2'h2,
    OP_READ_LIVE  = 2'h3
  } pud_op_t;

endpackage

// ===== core/pud_factory_rom.sv
// factory values of the start-up defaults map, by byte address
module pud_factory_rom
  import pud_pkg::*;
(
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    o_data = RST_UNUSED;
    if (i_addr >= OFS_NEG_CH && i_addr <= OFS_NEG_CH_LAST)
      o_data = RST_NEG_CH;
    else
      case (i_addr)
        OFS_FLEX_DIR:          o_data = RST_FLEX_DIR;
        OFS_FLEX_LVL:          o_data = RST_FLEX_LVL;
        OFS_FLEX_ANA:          o_data = RST_FLEX_ANA;
        OFS_EXT_DIR:           o_data = RST_EXT_DIR;
        OFS_EXT_LVL:           o_data = RST_EXT_LVL;
        OFS_EXT_ANA:           o_data = RST_EXT_ANA;
        OFS_CTL_DIR:           o_data = RST_CTL_DIR;
        OFS_CTL_LVL:           o_data = RST_CTL_LVL;
        OFS_UPD_MASK:          o_data = RST_UPD_MASK;
        OFS_TIMER_COUNT:       o_data = RST_TIMER_COUNT;
        OFS_CNT_ENABLE:        o_data = RST_CNT_ENABLE;
        OFS_PIN_START:         o_data = RST_PIN_START;
        OFS_OPTIONS:           o_data = RST_OPTIONS;
        OFS_TCLK_SEL:          o_data = RST_TCLK_SEL;
        OFS_TCLK_DIV:          o_data = RST_TCLK_DIV;
        OFS_T0_MODE:           o_data = RST_T0_MODE;
        OFS_T0_LOW:            o_data = RST_T0_LOW;
        OFS_T0_HIGH:           o_data = RST_T0_HIGH;
        OFS_T1_MODE:           o_data = RST_T1_MODE;
        OFS_T1_LOW:            o_data = RST_T1_LOW;
        OFS_T1_HIGH:           o_data = RST_T1_HIGH;
        OFS_AOUT0:             o_data = RST_AOUT0[7:0];
        8'(OFS_AOUT0 + 8'h01): o_data = RST_AOUT0[15:8];
        OFS_AOUT1:             o_data = RST_AOUT1[7:0];
        8'(OFS_AOUT1 + 8'h01): o_data = RST_AOUT1[15:8];
        default:               o_data = RST_UNUSED;
      endcase
  end

endmodule // pud_factory_rom

// ===== testbench/pud_host_model.sv
// flash array and live configuration map seen by the defaults store
module pud_host_model #(
  parameter int SLOW = 2
) (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic            o_ack,
  output logic      [7:0] o_rdata,
  input  wire logic [7:0] i_live_addr,
  output logic      [7:0] o_live_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] rd;
  int         cnt;
  // live map pattern, flash starts as inverse
  initial for (int i = 0; i < 256; i++) mem[i] = ~(i[7:0] ^ 8'h5A);
  assign o_live_data = i_live_addr ^ 8'h5A;
  // read data is only valid with the ack pulse
  assign o_rdata = o_ack ? rd : ~rd;
  always @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ack <= 1'b0;
      cnt   <= 0;
      rd    <= 8'h00;
    end
    else if (i_req && !o_ack && cnt >= SLOW)
    begin
      o_ack <= 1'b1;
      cnt   <= 0;
      rd    <= mem[i_addr];
      if (i_we) mem[i_addr] <= i_wdata;
    end
    else
    begin
      o_ack <= 1'b0;
      cnt   <= (i_req && !o_ack) ? cnt + 1 : 0;
    end
  end
endmodule // pud_host_model

// ===== testbench/tb.sv
// self-checking bench of the power-up defaults store
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pud_pkg::*;
  logic       i_clock = 0, i_nrst = 0, i_ce = 1, i_rx_valid = 0, i_rx_last = 0;
  logic       i_tx_ready = 0, o_rx_ready, o_tx_valid, o_tx_last, o_flash_req;
  logic       o_flash_we, i_flash_ack, o_busy;
  logic [7:0] i_rx_data = 0, o_tx_data, o_flash_addr, o_flash_wdata, i_flash_rdata;
  logic [7:0] o_live_addr, i_live_data;
  logic [7:0] rsp [40];
  int         rsp_n, fail_count = 0, tests_run = 0;
  always #20 i_clock = ~i_clock;
  pud_defaults_store u_pud_defaults_store (.i_clock, .i_nrst, .i_ce, .i_rx_valid,
    .i_rx_data, .i_rx_last, .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready,
    .o_flash_req, .o_flash_we, .o_flash_addr, .o_flash_wdata, .i_flash_ack, .i_flash_rdata,
    .o_live_addr, .i_live_data, .o_busy);
  pud_host_model #(.SLOW(3)) u_pud_host_model (.i_clock, .i_nrst, .i_req(o_flash_req),
    .i_we(o_flash_we), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata), .o_ack(i_flash_ack),
    .o_rdata(i_flash_rdata), .i_live_addr(o_live_addr), .o_live_data(i_live_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one command frame out, whole answer back
  task automatic xfer(input logic [7:0] b6, input logic [7:0] b7, input logic [7:0] bad,
                      input int last);
    logic [7:0]  f [8];
    logic [15:0] s;
    logic        done;
    s = b6 + b7;
    f = '{8'h00, 8'hF8, 8'h01, 8'h0E, s[7:0], s[15:8], b6, b7};
    f[0] = f[1] + f[2] + f[3] + f[4] + f[5] + bad;
    for (int i = 0; i <= last; i++)
    begin
      @(negedge i_clock);
      while (o_rx_ready !== 1'b1) @(negedge i_clock);
      i_rx_valid = 1;
      i_rx_data  = f[i];
      i_rx_last  = (i == last);
    end
    @(negedge i_clock);
    i_rx_valid = 0;
    i_rx_last  = 0;
    i_tx_ready = 1;
    check(o_busy, 1'b1);
    rsp_n = 0;
    done = 0;
    for (int k = 0; k < 20000 && !done; k++)
    begin
      @(negedge i_clock);
      // freeze a few cycles: nothing may be taken or skipped
      i_ce = (k < 5 || k > 8);
      if (i_ce && o_tx_valid === 1'b1 && rsp_n < 40)
      begin
        rsp[rsp_n] = o_tx_data;
        rsp_n++;
        done = (o_tx_last === 1'b1);
      end
    end
    @(negedge i_clock);
    check({o_busy, o_rx_ready, o_tx_valid}, 3'b010);
  endtask
  task automatic frame(input int n, input logic [7:0] err);
    logic [15:0] s;
    s = 0;
    for (int i = 6; i < n; i++) s += rsp[i];
    check(rsp_n[15:0], n[15:0]);
    check(rsp[1], 8'hF8);
    check(rsp[2], 8'h01);
    check(rsp[3], 8'h0E);
    check(rsp[0], 8'(rsp[1] + rsp[2] + rsp[3] + rsp[4] + rsp[5]));
    check({rsp[5], rsp[4]}, s);
    check(rsp[6], err);
    check(rsp[7], 8'h00);
  endtask
  task automatic t_read_live();
    xfer(8'h00, 8'h82, 0, 7);
    frame(40, ERR_NONE);
    for (int i = 0; i < 32; i++) check(rsp[8 + i], 8'(64 + i) ^ 8'h5A);
    $display("read live block done");
  endtask
  task automatic t_store(input logic [7:0] k0, input logic [7:0] k1, input logic fac);
    xfer(k0, k1, 0, 7);
    frame(8, ERR_NONE);
    for (int i = 0; i < 256; i++)
      if (!fac) check(u_pud_host_model.mem[i], 8'(i) ^ 8'h5A);
    if (fac)
    begin
      check(u_pud_host_model.mem[8'h05], 8'hFF);
      check(u_pud_host_model.mem[8'h13], 8'h04);
      check(u_pud_host_model.mem[8'h20], 8'h02);
      check(u_pud_host_model.mem[8'h30], 8'h0A);
      check(u_pud_host_model.mem[8'h60], 8'h1F);
      check(u_pud_host_model.mem[8'h50], 8'h00);
    end
    $display("store done");
  endtask
  task automatic t_read_flash();
    xfer(8'h00, 8'h01, 0, 7);
    frame(40, ERR_NONE);
    check(rsp[8], 8'h02);
    check(rsp[24], 8'h0A);
    check(rsp[28], 8'h0A);
    $display("read flash block done");
  endtask
  task automatic t_errors();
    xfer(8'h00, 8'h00, 8'h01, 7);
    check(rsp[6] != 8'h00, 1'b1);
    frame(40, ERR_CHECKSUM);
    xfer(8'h00, 8'h88, 0, 7);
    frame(40, ERR_BLOCK);
    xfer(8'h11, 8'h22, 0, 7);
    frame(8, ERR_KEY);
    xfer(8'h00, 8'h01, 0, 3);
    frame(8, ERR_FRAME);
    $display("error answers done");
  endtask
  initial
  begin
    #(40 * 60000);
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    i_nrst = 1;
    t_read_live();
    t_store(8'hBA, 8'h26, 0);
    t_store(8'h82, 8'hC7, 1);
    t_read_flash();
    t_errors();
    complete_run();
  end
endmodule // tb
